// File: rrn_params.svh
`ifndef RRN_PARAMS_SVH
`define RRN_PARAMS_SVH

// instruction word layout
`define RRN_INSTR_W        14
`define RRN_PC_W           13
`define RRN_DATA_W         8
`define RRN_FADDR_W        7
`define RRN_DEST_BIT       7
`define RRN_MSB_BIT        7

// opcode patterns and their compare masks
`define RRN_OP_NOP         14'h0000
`define RRN_MASK_NOP       14'h3F9F
`define RRN_OP_RETIRQ      14'h0009
`define RRN_OP_RETURN      14'h0008
`define RRN_MASK_FULL      14'h3FFF
`define RRN_OP_RETLIT      14'h3400
`define RRN_MASK_RETLIT    14'h3C00
`define RRN_OP_ROTL        14'h0D00
`define RRN_MASK_ROTL      14'h3F00

// interrupt control register: enable bit position and reset value
`define RRN_IRQEN_BIT      7
`define RRN_INTCTL_RST     8'h00

// reset values
`define RRN_PC_RST         13'h0000
`define RRN_W_RST          8'h00

// cycle counts per instruction
`define RRN_CYC_ONE        1
`define RRN_CYC_TWO        2

// return stack depth
`define RRN_STACK_DEPTH    8

`endif

// File: rrn_pkg.sv
package rrn_pkg;

  typedef enum logic [0:0] {
    RRN_ST_EXEC,
    RRN_ST_FLUSH
  } rrn_state_t;

  typedef enum logic [2:0] {
    RRN_K_NOP,
    RRN_K_RETIRQ,
    RRN_K_RETURN,
    RRN_K_RETLIT,
    RRN_K_ROTL,
    RRN_K_OTHER
  } rrn_kind_t;

endpackage

// File: rrn_stack.sv
`timescale 1ns/1ns
`include "rrn_params.svh"

module rrn_stack #(
  parameter int DEPTH = `RRN_STACK_DEPTH,
  parameter int WIDTH = `RRN_PC_W
) (
  input  wire logic             ref_clk_in,  // core clock
  input  wire logic             rst_b_in,    // async reset, active low
  input  wire logic             push_in,     // push push_data_in
  input  wire logic [WIDTH-1:0] push_data_in,// return address to save
  input  wire logic             pop_in,      // drop top entry
  output logic      [WIDTH-1:0] top_out      // current top entry
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    ptr_q;
  logic [PW-1:0]    ptr_up;
  logic [PW-1:0]    ptr_dn;
  logic [PW-1:0]    wr_idx;

  // circular stack: overflow overwrites the oldest entry
  assign ptr_up  = (ptr_q == PW'(DEPTH - 1)) ? '0 : ptr_q + PW'(1);
  assign ptr_dn  = (ptr_q == '0) ? PW'(DEPTH - 1) : ptr_q - PW'(1);
  assign wr_idx  = pop_in ? ptr_q : ptr_up;
  assign top_out = mem_q[ptr_q];

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ptr_q <= '0;
    end
    else if (push_in != pop_in)
    begin
      ptr_q <= push_in ? ptr_up : ptr_dn;
    end
  end

  // push and pop together replace the top entry
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
    end
    else if (push_in)
    begin
      mem_q[wr_idx] <= push_data_in;
    end
  end

endmodule

// File: rrn_exec.sv
`timescale 1ns/1ns
`include "rrn_params.svh"

module rrn_exec #(
  parameter int STACK_DEPTH = `RRN_STACK_DEPTH
) (
  input  wire logic                      ref_clk_in,     // 20 MHz core clock
  input  wire logic                      rst_b_in,       // async reset, low
  input  wire logic [`RRN_INSTR_W-1:0]   instr_in,       // instruction word
  input  wire logic                      instr_valid_in, // instr_in valid
  output logic                           instr_ready_out,// instruction taken
  input  wire logic                      push_in,        // call: save address
  input  wire logic [`RRN_PC_W-1:0]      push_addr_in,   // address to save
  input  wire logic                      irq_en_clear_in,// irq entry clears enable; a retirq taken in the same cycle sets it
  input  wire logic [`RRN_DATA_W-1:0]    file_rdata_in,  // file register data
  output logic      [`RRN_FADDR_W-1:0]   file_addr_out,  // file register addr
  output logic      [`RRN_DATA_W-1:0]    file_wdata_out, // write-back data
  output logic                           file_we_out,    // write-back strobe
  output logic      [`RRN_PC_W-1:0]      pc_out,         // program counter
  output logic      [`RRN_DATA_W-1:0]    w_out,          // accumulator
  output logic                           carry_out,      // carry flag
  output logic      [`RRN_DATA_W-1:0]    intctl_out,     // interrupt control
  output logic                           illegal_out     // unsupported opcode
);

  rrn_pkg::rrn_state_t state_q;
  rrn_pkg::rrn_state_t state_d;
  rrn_pkg::rrn_kind_t  kind;

  logic [`RRN_PC_W-1:0]   pc_q;
  logic [`RRN_PC_W-1:0]   pc_d;
  logic [`RRN_DATA_W-1:0] w_q;
  logic [`RRN_DATA_W-1:0] w_d;
  logic                   carry_q;
  logic                   carry_d;
  logic [`RRN_DATA_W-1:0] intctl_q;
  logic [`RRN_DATA_W-1:0] intctl_d;
  logic [`RRN_DATA_W-1:0] fwd_q;
  logic                   fwe_q;
  logic                   ill_q;
  logic [`RRN_PC_W-1:0]   stack_top;

  wire take      = instr_valid_in && instr_ready_out;
  wire is_nop    = (instr_in & `RRN_MASK_NOP) == `RRN_OP_NOP;
  wire is_retirq = (instr_in & `RRN_MASK_FULL) == `RRN_OP_RETIRQ;
  wire is_return = (instr_in & `RRN_MASK_FULL) == `RRN_OP_RETURN;
  wire is_retlit = (instr_in & `RRN_MASK_RETLIT) == `RRN_OP_RETLIT;
  wire is_rotl   = (instr_in & `RRN_MASK_ROTL) == `RRN_OP_ROTL;
  wire is_ret    = is_retirq || is_return || is_retlit;
  wire dest_file = instr_in[`RRN_DEST_BIT];
  wire [`RRN_DATA_W-1:0] literal = instr_in[`RRN_DATA_W-1:0];
  wire [`RRN_PC_W-1:0]   pc_inc  = pc_q + `RRN_PC_W'(1);

  // rotate left through carry
  wire [`RRN_DATA_W-1:0] rot_res =
    {file_rdata_in[`RRN_DATA_W-2:0], carry_q};
  wire rot_carry = file_rdata_in[`RRN_MSB_BIT];

  assign kind = is_retirq ? rrn_pkg::RRN_K_RETIRQ :
                is_return ? rrn_pkg::RRN_K_RETURN :
                is_retlit ? rrn_pkg::RRN_K_RETLIT :
                is_rotl   ? rrn_pkg::RRN_K_ROTL   :
                is_nop    ? rrn_pkg::RRN_K_NOP    :
                            rrn_pkg::RRN_K_OTHER;

  // second cycle of a two-cycle return is a flush: nothing is taken
  assign instr_ready_out = (state_q == rrn_pkg::RRN_ST_EXEC);
  assign file_addr_out   = instr_in[`RRN_FADDR_W-1:0];

  rrn_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (`RRN_PC_W)
  ) u_stack (
    .ref_clk_in   (ref_clk_in),
    .rst_b_in     (rst_b_in),
    .push_in      (push_in),
    .push_data_in (push_addr_in),
    .pop_in       (take && is_ret),
    .top_out      (stack_top)
  );

  always_comb
  begin
    state_d  = rrn_pkg::RRN_ST_EXEC;
    pc_d     = pc_q;
    w_d      = w_q;
    carry_d  = carry_q;
    intctl_d = intctl_q;
    if (irq_en_clear_in)
    begin
      intctl_d[`RRN_IRQEN_BIT] = 1'b0;
    end
    if (take)
    begin
      case (kind)
        rrn_pkg::RRN_K_RETIRQ:
        begin
          pc_d                     = stack_top;
          intctl_d[`RRN_IRQEN_BIT] = 1'b1;
          state_d                = rrn_pkg::RRN_ST_FLUSH;
        end
        rrn_pkg::RRN_K_RETURN:
        begin
          pc_d    = stack_top;
          state_d = rrn_pkg::RRN_ST_FLUSH;
        end
        rrn_pkg::RRN_K_RETLIT:
        begin
          w_d     = literal;
          pc_d    = stack_top;
          state_d = rrn_pkg::RRN_ST_FLUSH;
        end
        rrn_pkg::RRN_K_ROTL:
        begin
          pc_d    = pc_inc;
          carry_d = rot_carry;
          if (!dest_file)
          begin
            w_d = rot_res;
          end
        end
        default:
        begin
          pc_d = pc_inc;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q  <= rrn_pkg::RRN_ST_EXEC;
      pc_q     <= `RRN_PC_RST;
      w_q      <= `RRN_W_RST;
      carry_q  <= 1'b0;
      intctl_q <= `RRN_INTCTL_RST;
    end
    else
    begin
      state_q  <= state_d;
      pc_q     <= pc_d;
      w_q      <= w_d;
      carry_q  <= carry_d;
      intctl_q <= intctl_d;
    end
  end

  // file write-back strobe and data, one cycle after the rotate is taken
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      fwd_q <= '0;
      fwe_q <= 1'b0;
      ill_q <= 1'b0;
    end
    else
    begin
      fwe_q <= take && is_rotl && dest_file;
      fwd_q <= rot_res;
      ill_q <= take && (kind == rrn_pkg::RRN_K_OTHER);
    end
  end

  assign pc_out         = pc_q;
  assign w_out          = w_q;
  assign carry_out      = carry_q;
  assign intctl_out     = intctl_q;
  assign file_wdata_out = fwd_q;
  assign file_we_out    = fwe_q;
  assign illegal_out    = ill_q;

endmodule

// File: rrn_exec_assertions.sv
`timescale 1ns/1ns
`include "rrn_params.svh"
module rrn_exec_assertions (
  input wire logic                    ref_clk_in,      // clock
  input wire logic                    rst_b_in,        // reset, low
  input wire logic [`RRN_INSTR_W-1:0] instr_in,        // word
  input wire logic                    instr_valid_in,  // valid
  input wire logic                    instr_ready_out, // ready
  input wire logic [`RRN_DATA_W-1:0]  file_rdata_in,   // file data
  input wire logic [`RRN_DATA_W-1:0]  file_wdata_out,  // write data
  input wire logic                    file_we_out,     // write strobe
  input wire logic [`RRN_PC_W-1:0]    pc_out,          // pc
  input wire logic [`RRN_DATA_W-1:0]  w_out,           // accumulator
  input wire logic                    carry_out,       // carry
  input wire logic [`RRN_DATA_W-1:0]  intctl_out       // irq control
);
  wire logic tk = instr_valid_in && instr_ready_out;
  wire logic rotl = tk && ((instr_in & `RRN_MASK_ROTL) == `RRN_OP_ROTL);
  wire logic rlw = tk && ((instr_in & `RRN_MASK_RETLIT) == `RRN_OP_RETLIT);
  wire logic rfi = tk && (instr_in == `RRN_OP_RETIRQ);
  wire logic ret = rlw || rfi || (tk && instr_in == `RRN_OP_RETURN);
  wire logic nop = tk && (instr_in == `RRN_OP_NOP);
  wire logic [7:0] rot = {file_rdata_in[6:0], carry_out};
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_nop;
    nop |=> pc_out == $past(pc_out) + 1'b1 && $stable(w_out)
      && $stable(carry_out) && $stable(intctl_out) && !file_we_out;
  endproperty
  a_nop: assert property (p_nop)
    else $error("nop changed state");
  property p_rotl_c;
    rotl |=> carry_out == $past(file_rdata_in[7])
      && pc_out == $past(pc_out) + 1'b1;
  endproperty
  a_rotl_c: assert property (p_rotl_c)
    else $error("rotate carry wrong");
  property p_rotl_w;
    rotl && !instr_in[`RRN_DEST_BIT] |=> w_out == $past(rot) && !file_we_out;
  endproperty
  a_rotl_w: assert property (p_rotl_w)
    else $error("rotate to accumulator wrong");
  property p_rotl_f;
    rotl && instr_in[`RRN_DEST_BIT] |=> file_we_out && $stable(w_out)
      && file_wdata_out == $past(rot);
  endproperty
  a_rotl_f: assert property (p_rotl_f)
    else $error("rotate write-back wrong");
  property p_rlw;
    rlw |=> w_out == $past(instr_in[7:0]);
  endproperty
  a_rlw: assert property (p_rlw)
    else $error("literal not loaded");
  property p_ret;
    ret |=> $stable(carry_out) && !instr_ready_out ##1 instr_ready_out;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return not two cycles");
  property p_rfi;
    rfi |=> intctl_out[`RRN_IRQEN_BIT];
  endproperty
  a_rfi: assert property (p_rfi)
    else $error("global enable not set");
  c_rotl: cover property (rotl);
  c_rlw: cover property (rlw);
  c_rfi: cover property (rfi);
endmodule
bind rrn_exec rrn_exec_assertions u_chk (.ref_clk_in, .rst_b_in, .instr_in,
  .instr_valid_in, .instr_ready_out, .file_rdata_in, .file_wdata_out,
  .file_we_out, .pc_out, .w_out, .carry_out, .intctl_out);

// File: tb_return_rotate_nop_exec.sv
`timescale 1ns/1ns
`include "rrn_params.svh"
module tb_return_rotate_nop_exec;
  logic ref_clk_in = 0, rst_b_in = 0, instr_valid_in = 0, push_in = 0;
  logic irq_en_clear_in = 0, took = 0, mc = 0, mg = 0;
  logic [13:0] instr_in = 0;
  logic [12:0] push_addr_in = 0, mpc = 0, stk [8];
  logic [7:0] file_rdata_in = 0, mw = 0;
  logic [2:0] sp = 0;
  logic [39:0] exp_q [$], got, e;
  wire logic instr_ready_out, file_we_out, carry_out, illegal_out;
  wire logic [6:0] file_addr_out;
  wire logic [7:0] file_wdata_out, w_out, intctl_out;
  wire logic [12:0] pc_out;
  int n_fail = 0, n_compared = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  rrn_exec uut (.ref_clk_in, .rst_b_in, .instr_in, .instr_valid_in,
    .instr_ready_out, .push_in, .push_addr_in, .irq_en_clear_in,
    .file_rdata_in, .file_addr_out, .file_wdata_out, .file_we_out, .pc_out,
    .w_out, .carry_out, .intctl_out, .illegal_out);
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // stack entry, or idle cycle when en is low
  task automatic do_push(input logic [12:0] a, input logic clr, input logic en);
    @(negedge ref_clk_in);
    instr_valid_in = 1'b0;
    push_in = en;
    irq_en_clear_in = clr;
    push_addr_in = a;
    if (en)
    begin
      stk[sp] = a;
      sp = sp + 3'h1;
      if (clr) mg = 1'b0;
    end
  endtask
  task automatic do_op(input logic [13:0] op, input logic [7:0] rd);
    logic [7:0] r;
    logic wb;
    logic ill;
    r = {rd[6:0], mc};
    wb = 1'b0;
    ill = 1'b0;
    @(negedge ref_clk_in);
    push_in = 1'b0;
    irq_en_clear_in = 1'b0;
    instr_in = op;
    file_rdata_in = rd;
    instr_valid_in = 1'b1;
    while (instr_ready_out !== 1'b1) @(negedge ref_clk_in);
    n_compared++;
    if (file_addr_out !== op[6:0])
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, file_addr_out, op[6:0]);
    end
    mpc = mpc + 13'h0001;
    if ((op & `RRN_MASK_ROTL) == `RRN_OP_ROTL)
    begin
      mc = rd[7];
      wb = op[`RRN_DEST_BIT];
      if (!wb) mw = r;
    end
    else if ((op & `RRN_MASK_RETLIT) == `RRN_OP_RETLIT
             || op == `RRN_OP_RETURN || op == `RRN_OP_RETIRQ)
    begin
      sp = sp - 3'h1;
      mpc = stk[sp];
      if (op == `RRN_OP_RETIRQ) mg = 1'b1;
      if (op[13:12] == 2'h3) mw = op[7:0];
    end
    else if ((op & `RRN_MASK_NOP) != `RRN_OP_NOP)
    begin
      ill = 1'b1;
    end
    exp_q.push_back({mpc, mw, mc, mg, 7'h00, wb, wb ? r : 8'h00, ill});
    @(posedge ref_clk_in);
  endtask
  always @(posedge ref_clk_in) took <= instr_valid_in && instr_ready_out;
  always @(negedge ref_clk_in)
    if (took === 1'b1 && exp_q.size() > 0)
    begin
      got = {pc_out, w_out, carry_out, intctl_out, file_we_out,
             file_we_out ? file_wdata_out : 8'h00, illegal_out};
      e = exp_q.pop_front();
      n_compared++;
      if (got !== e)
      begin
        n_fail++;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, e);
      end
    end
  initial
  begin
    repeat (2000) @(posedge ref_clk_in);
    n_fail++;
    $display("watchdog expired");
    summarize;
  end
  initial
  begin
    void'($urandom(32'h6f58_ff63));
    foreach (stk[i]) stk[i] = 13'h0000;
    repeat (8) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    repeat (3) do_op(`RRN_OP_NOP, 8'($urandom));
    $display("test nop done");
    do_op(`RRN_OP_ROTL | 14'h0005, 8'hE6);
    repeat (24)
      do_op(`RRN_OP_ROTL | 14'($urandom_range(0, 255)), 8'($urandom));
    $display("test rotate done");
    repeat (4) do_push(13'($urandom), 1'b1, 1'b1);
    do_op(`RRN_OP_RETLIT | 14'h00FF, 8'($urandom));
    do_op(`RRN_OP_RETLIT, 8'($urandom));
    do_op(`RRN_OP_RETURN, 8'($urandom));
    do_op(`RRN_OP_RETIRQ, 8'($urandom));
    do_op(`RRN_OP_ROTL | 14'h0080, 8'($urandom));
    $display("test return done");
    do_op(14'h3000, 8'($urandom));
    do_op(`RRN_OP_NOP | 14'h0060, 8'($urandom));
    $display("test illegal done");
    repeat (2) do_push(13'h0000, 1'b0, 1'b0);
    summarize;
  end
endmodule
